//--- core/cic_pkg.sv
// constants shared by the interrupt control logic
package cic_pkg;
  localparam int AXI_AW = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PFLAG = 4'h4;
  localparam logic [3:0] ADDR_PENA = 4'h8;
  localparam logic [3:0] ADDR_OPT = 4'hc;
  localparam int CTRL_GIE = 7;
  localparam int CTRL_PGIE = 6;
  localparam int CTRL_CORE_IE = 5;
  localparam int CTRL_EXT_IE = 4;
  localparam int CTRL_CORE_IF = 2;
  localparam int CTRL_EXT_IF = 1;
  localparam int OPT_EDGE = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PFLAG_RST = 8'h00;
  localparam logic [7:0] PENA_RST = 8'h00;
  localparam logic OPT_EDGE_RST = 1'h1;
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam int CTX_W = 64;
  localparam logic [63:0] CTX_KEEP_MASK = 64'h0000_0000_0000_1800;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_FLUSH = 2'b01,
    RD_LOAD = 2'b10
  } cic_redir_t;
endpackage

//--- core/cic_shadow.sv
// shadow context store with registered read data
`timescale 1ns/1ps
module cic_shadow #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 1,
  parameter int AW = 1
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) $error("cic_shadow: bad DEPTH");
  end

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    rdata <= mem[raddr];
  end
endmodule

//--- core/cic_core_irq.sv
// interrupt control: flags, enables, redirect sequence, context save, AXI4-Lite registers
`timescale 1ns/1ps
// How it works
// RULE1 - any reset clears the global enable so nothing redirects
// RULE2 - redirect needs global and source enable, peripheral sources also group enable
// RULE3 - flags set on their event whatever the enables say
// RULE4 - entry flushes prefetch, clears global enable, pushes pc, saves context, loads 0004h
// RULE5 - with global enable clear events only flag; pending one taken when re-enabled
// RULE6 - return pops address, restores context, sets global enable
// RULE7 - service code clears handled flags before return or re-enters at once
// RULE8 - service code polls flags to find the source of the shared vector
// RULE9 - synchronous event to first vector instruction takes three to four cycles
// RULE10 - external edge event latency is three to five instruction cycles
// RULE11 - latency is the same for one- and two-cycle instructions
// RULE12 - redirect logic samples pending flags once per cycle in first quarter
// RULE13 - external edge flag may set from fourth quarter through next first quarter
// RULE14 - external flag sets on rising edge when polarity one, falling when zero
// RULE15 - working, status less timeout/power-down, bank, pointers, latch-high shadowed
// RULE16 - on wake with global enable set, next instruction runs before the vector
// RULE17 - instruction cycle is four quarter phases; latencies count whole cycles
// RULE18 - asynchronous inputs are synchronised before they set flags
module cic_core_irq
  import cic_pkg::*;
#(
  parameter int NPER = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [NPER-1:0] periphEvent,
  input wire logic coreEvent,
  input wire logic extIrqPin,
  input wire logic [15:0] curPc,
  input wire logic cpuAsleep,
  input wire logic retfieExec,
  input wire logic [CTX_W-1:0] ctxLive,
  output logic [1:0] qPhase,
  output logic flushInstr,
  output logic stackPush,
  output logic [15:0] pushPc,
  output logic pcLoad,
  output logic [15:0] pcLoadAddr,
  output logic stackPop,
  output logic ctxRestore,
  output logic [CTX_W-1:0] ctxRestored,
  output logic wakeReq
);
  initial begin
    if (NPER < 1 || NPER > 8) $error("cic_core_irq: NPER must be 1..8");
  end

  logic global_irq_enable, pgie, coreIe, extIe, coreIf, extIf, extPol;
  logic [NPER-1:0] pflag, pena;
  logic awFull, wFull;
  logic [AXI_AW-1:0] awHeld;
  logic [7:0] wHeld;
  logic wLane0;
  logic extSync1, extSync2, extSync3, edgePend;
  logic asleepD, wakeSkip;
  cic_redir_t state;
  logic [CTX_W-1:0] shadowRd;

  // quarter phase sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      qPhase <= PH_Q1;
    end else begin
      qPhase <= qPhase + 2'h1; // [RULE17]
    end
  end

  logic cycStart;
  assign cycStart = (qPhase == PH_Q1);

  // write channel: address and data may arrive in either order
  logic wrEn, wrCtrl, wrPf, wrPe, wrOpt;
  assign awready = !awFull;
  assign wready = !wFull;
  assign wrEn = awFull && wFull && !bvalid;
  assign wrCtrl = wrEn && wLane0 && (awHeld == ADDR_CTRL);
  assign wrPf = wrEn && wLane0 && (awHeld == ADDR_PFLAG);
  assign wrPe = wrEn && wLane0 && (awHeld == ADDR_PENA);
  assign wrOpt = wrEn && wLane0 && (awHeld == ADDR_OPT);

  logic mapped;
  assign mapped = (awHeld == ADDR_CTRL) || (awHeld == ADDR_PFLAG) ||
                  (awHeld == ADDR_PENA) || (awHeld == ADDR_OPT);

  always_ff @(posedge mclk) begin
    if (rst) begin
      awFull <= 1'b0;
      wFull <= 1'b0;
      awHeld <= '0;
      wHeld <= 8'h00;
      wLane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awFull <= 1'b1;
        awHeld <= awaddr;
      end
      if (wvalid && wready) begin
        wFull <= 1'b1;
        wHeld <= wdata[7:0];
        wLane0 <= wstrb[0];
      end
      if (wrEn) begin
        awFull <= 1'b0;
        wFull <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel
  logic [7:0] ctrlRd;
  assign ctrlRd = {global_irq_enable, pgie, coreIe, extIe, 1'b0, coreIf, extIf, 1'b0};
  assign arready = !rvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      unique case (araddr)
        ADDR_CTRL: rdata <= {24'h00_0000, ctrlRd};
        ADDR_PFLAG: rdata <= {{(32-NPER){1'b0}}, pflag};
        ADDR_PENA: rdata <= {{(32-NPER){1'b0}}, pena};
        ADDR_OPT: rdata <= {31'h0000_0000, extPol};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // external edge input: two-stage synchroniser, then edge detect
  // stages are not reset: a pin held high through reset must not look like an edge
  always_ff @(posedge mclk) begin
    extSync1 <= extIrqPin; // [RULE18]
    extSync2 <= extSync1;
    extSync3 <= extSync2;
  end

  // detector armed once the stages hold real pin values; edges in that gap are lost
  logic [1:0] extArm;
  always_ff @(posedge mclk) begin
    if (rst) begin
      extArm <= 2'b00;
    end else begin
      extArm <= {extArm[0], 1'b1};
    end
  end

  logic extEdge, extWin, extSet;
  assign extEdge = extArm[1] &&
                   (extPol ? (extSync2 && !extSync3) : (!extSync2 && extSync3)); // [RULE14]
  // an edge seen in Q2/Q3 waits for the Q4-Q1 window, costing up to two quarter phases
  assign extWin = (qPhase == PH_Q4) || (qPhase == PH_Q1);
  assign extSet = (extEdge || edgePend) && extWin; // [RULE13] [RULE10]

  always_ff @(posedge mclk) begin
    if (rst) begin
      edgePend <= 1'b0;
    end else if (extWin) begin
      edgePend <= 1'b0;
    end else if (extEdge) begin
      edgePend <= 1'b1;
    end
  end

  // control bits; a hardware set beats a software clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pgie <= CTRL_RST[CTRL_PGIE];
      coreIe <= CTRL_RST[CTRL_CORE_IE];
      extIe <= CTRL_RST[CTRL_EXT_IE];
      extPol <= OPT_EDGE_RST;
      pena <= PENA_RST[NPER-1:0];
    end else begin
      if (wrCtrl) begin
        pgie <= wHeld[CTRL_PGIE];
        coreIe <= wHeld[CTRL_CORE_IE];
        extIe <= wHeld[CTRL_EXT_IE];
      end
      if (wrOpt) begin
        extPol <= wHeld[OPT_EDGE];
      end
      if (wrPe) begin
        pena <= wHeld[NPER-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      coreIf <= CTRL_RST[CTRL_CORE_IF];
      extIf <= CTRL_RST[CTRL_EXT_IF];
      pflag <= PFLAG_RST[NPER-1:0];
    end else begin
      coreIf <= (wrCtrl ? wHeld[CTRL_CORE_IF] : coreIf) | coreEvent; // [RULE3]
      extIf <= (wrCtrl ? wHeld[CTRL_EXT_IF] : extIf) | extSet; // [RULE3]
      pflag <= (wrPf ? wHeld[NPER-1:0] : pflag) | periphEvent; // [RULE3]
    end
  end

  // one shared vector: software polls the flags to find the cause [RULE8]
  logic pending, take, justWoke;
  assign justWoke = asleepD && !cpuAsleep;
  assign pending = (coreIf && coreIe) || (extIf && extIe) || (pgie && |(pflag & pena)); // [RULE2]
  assign wakeReq = pending;
  // flag left set at return re-enters here at once [RULE7]
  // instruction length is not looked at, so both kinds see the same latency [RULE11]
  assign take = cycStart && global_irq_enable && pending && (state == RD_IDLE) && !cpuAsleep &&
                !wakeSkip && !justWoke; // [RULE12] [RULE5] [RULE9] [RULE16]

  // wake from sleep: the first Q1 sample at or after wake is skipped, so the
  // instruction after sleep runs first; the wake edge itself may be that Q1
  always_ff @(posedge mclk) begin
    if (rst) begin
      asleepD <= 1'b0;
      wakeSkip <= 1'b0;
    end else begin
      asleepD <= cpuAsleep;
      if (justWoke && !cycStart) begin
        wakeSkip <= 1'b1; // [RULE16]
      end else if (cycStart) begin
        wakeSkip <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      global_irq_enable <= CTRL_RST[CTRL_GIE]; // [RULE1]
    end else if (take) begin
      global_irq_enable <= 1'b0; // [RULE4]
    end else if (retfieExec) begin
      global_irq_enable <= 1'b1; // [RULE6]
    end else if (wrCtrl) begin
      global_irq_enable <= wHeld[CTRL_GIE];
    end
  end

  // redirect sequence: one cycle of flush, one cycle of vector load
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= RD_IDLE;
    end else begin
      unique case (state)
        RD_IDLE: if (take) state <= RD_FLUSH;
        RD_FLUSH: if (cycStart) state <= RD_LOAD;
        RD_LOAD: if (cycStart) state <= RD_IDLE;
        default: state <= RD_IDLE;
      endcase
    end
  end

  assign flushInstr = (state == RD_FLUSH); // [RULE4]

  always_ff @(posedge mclk) begin
    if (rst) begin
      stackPush <= 1'b0;
      pushPc <= 16'h0000;
      pcLoad <= 1'b0;
      pcLoadAddr <= 16'h0000;
      stackPop <= 1'b0;
      ctxRestore <= 1'b0;
    end else begin
      stackPush <= take; // [RULE4]
      if (take) begin
        pushPc <= curPc;
      end
      pcLoad <= (state == RD_FLUSH) && cycStart;
      pcLoadAddr <= IRQ_VECTOR; // [RULE4]
      stackPop <= retfieExec; // [RULE6]
      ctxRestore <= retfieExec;
    end
  end

  cic_shadow #(
    .WIDTH(CTX_W),
    .DEPTH(1),
    .AW(1)
  ) u_shadow (
    .mclk(mclk),
    .we(take), // [RULE15]
    .waddr(1'b0),
    .wdata(ctxLive),
    .raddr(1'b0),
    .rdata(shadowRd)
  );

  // timeout and power-down status bits are never rolled back
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctxRestored <= '0;
    end else if (retfieExec) begin
      ctxRestored <= (shadowRd & ~CTX_KEEP_MASK) | (ctxLive & CTX_KEEP_MASK); // [RULE15]
    end
  end

  sequence s_entry;
    flushInstr && stackPush && !global_irq_enable;
  endsequence

  sequence s_load;
    pcLoad && (pcLoadAddr == IRQ_VECTOR);
  endsequence

  property p_gie_reset;
    @(posedge mclk) rst |=> !global_irq_enable;
  endproperty
  a_gie_reset: assert property (p_gie_reset) else $error("gie set after reset"); // [RULE1]

  property p_take_enabled;
    @(posedge mclk) disable iff (rst) $rose(flushInstr) |-> $past(pending);
  endproperty
  a_take_enabled: assert property (p_take_enabled) else $error("redirect w/o enable"); // [RULE2]

  property p_flag_set;
    @(posedge mclk) disable iff (rst) coreEvent |=> coreIf;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on event"); // [RULE3]

  property p_entry;
    @(posedge mclk) disable iff (rst) $rose(flushInstr) |-> s_entry ##4 s_load;
  endproperty
  a_entry: assert property (p_entry) else $error("entry sequence wrong"); // [RULE4]

  property p_gie_gate;
    @(posedge mclk) disable iff (rst) $rose(flushInstr) |-> $past(global_irq_enable);
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("redirect with gie clear"); // [RULE5]

  property p_return;
    @(posedge mclk) disable iff (rst) retfieExec |=> stackPop && ctxRestore && global_irq_enable;
  endproperty
  a_return: assert property (p_return) else $error("return sequence wrong"); // [RULE6]

  property p_sync_latency;
    @(posedge mclk) disable iff (rst)
      (coreEvent && coreIe && global_irq_enable && state == RD_IDLE && !cpuAsleep && !wakeSkip &&
       !asleepD && !wrEn && !retfieExec) |-> ##[1:9] pcLoad;
  endproperty
  a_sync_latency: assert property (p_sync_latency) else $error("sync latency"); // [RULE9]

  property p_sample_q1;
    @(posedge mclk) disable iff (rst) $rose(flushInstr) |-> $past(qPhase) == PH_Q1;
  endproperty
  a_sample_q1: assert property (p_sample_q1) else $error("sample not in Q1"); // [RULE12]

  property p_ext_window;
    @(posedge mclk) disable iff (rst)
      $rose(extIf) && !$past(wrCtrl) |-> $past(qPhase) == PH_Q4 || $past(qPhase) == PH_Q1;
  endproperty
  a_ext_window: assert property (p_ext_window) else $error("ext flag outside Q4-Q1"); // [RULE13]

  property p_ext_edge;
    @(posedge mclk) disable iff (rst)
      extArm[1] && extPol && $rose(extSync2) && !wrCtrl && !wrOpt |-> ##[1:4] extIf;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("rising edge missed"); // [RULE14]

  property p_restore_keep;
    @(posedge mclk) disable iff (rst)
      retfieExec |=> (ctxRestored & CTX_KEEP_MASK) == ($past(ctxLive) & CTX_KEEP_MASK);
  endproperty
  a_restore_keep: assert property (p_restore_keep) else $error("to/pd restored"); // [RULE15]

  property p_wake;
    @(posedge mclk) disable iff (rst) $fell(cpuAsleep) && !flushInstr |=> !flushInstr[*4];
  endproperty
  a_wake: assert property (p_wake) else $error("vector before post-sleep instr"); // [RULE16]

  property p_phase;
    @(posedge mclk) disable iff (rst) qPhase == PH_Q4 |=> qPhase == PH_Q1;
  endproperty
  a_phase: assert property (p_phase) else $error("phase order"); // [RULE17]
endmodule

//--- testbench/cic_seq_model.sv
// sequencer stand-in: program counter and live context seen by the block
`timescale 1ns/1ps
module cic_seq_model
  import cic_pkg::*;
#(
  parameter logic [63:0] STEP = 64'h0101_0101_0101_0901
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic stackPush,
  input wire logic [15:0] pushPc,
  input wire logic pcLoad,
  input wire logic [15:0] pcLoadAddr,
  input wire logic stackPop,
  output logic [15:0] curPc,
  output logic [CTX_W-1:0] ctxLive
);
  logic [15:0] savedPc;
  always_ff @(posedge mclk) begin
    if (rst) begin
      curPc <= 16'h0100;
    end else if (pcLoad) begin
      curPc <= pcLoadAddr;
    end else if (stackPop) begin
      curPc <= savedPc;
    end else begin
      curPc <= curPc + 16'h0001;
    end
  end
  always_ff @(posedge mclk) begin
    if (stackPush) begin
      savedPc <= pushPc;
    end
  end
  // context moves every clock, tracing bits included, so a stale save shows
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctxLive <= 64'h0011_2233_4455_6677;
    end else begin
      ctxLive <= ctxLive + STEP;
    end
  end
endmodule

//--- testbench/cic_testbench.sv
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
module testbench;
  import cic_pkg::*;
  localparam logic [63:0] STEP = 64'h0101_0101_0101_0901;
  logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, coreEvent, extIrqPin, cpuAsleep, retfieExec, flushInstr, stackPush;
  logic pcLoad, stackPop, ctxRestore, wakeReq;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, qPhase;
  logic [7:0] periphEvent;
  logic [15:0] curPc, pushPc, pcLoadAddr;
  logic [CTX_W-1:0] ctxLive, ctxRestored, saved;
  int miscompares, testsRun;

  cic_core_irq #(.NPER(8)) dut_u (.mclk(mclk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .periphEvent(periphEvent), .coreEvent(coreEvent),
    .extIrqPin(extIrqPin), .curPc(curPc), .cpuAsleep(cpuAsleep), .retfieExec(retfieExec),
    .ctxLive(ctxLive), .qPhase(qPhase), .flushInstr(flushInstr), .stackPush(stackPush),
    .pushPc(pushPc), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .stackPop(stackPop),
    .ctxRestore(ctxRestore), .ctxRestored(ctxRestored), .wakeReq(wakeReq));

  cic_seq_model #(.STEP(STEP)) seq_u (.mclk(mclk), .rst(rst), .stackPush(stackPush),
    .pushPc(pushPc), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .stackPop(stackPop),
    .curPc(curPc), .ctxLive(ctxLive));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic testDone();
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // every bus task starts on a fresh edge so no signal is driven twice in one step
  task automatic axiWr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({i < 40, bresp}, {1'b1, er}, "write");
  endtask

  task automatic axiRd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk({i < 40, rresp, rdata}, {1'b1, er, ed}, "read");
  endtask

  task automatic noPush(input int n);
    repeat (n) begin
      @(posedge mclk);
      chk(stackPush, 1'b0, "unexpected entry");
    end
  endtask

  task automatic waitVec(input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (stackPush !== 1'b1 && n < lim);
    chk(stackPush, 1'b1, "entry");
    chk(flushInstr, 1'b1, "flush");
    chk(qPhase, PH_Q1 + 2'h1, "take phase");
    chk(pushPc, curPc - 16'h0001, "pushed pc");
    saved = ctxLive - STEP;
    repeat (4) @(posedge mclk);
    n += 4;
    chk({pcLoad, pcLoadAddr}, {1'b1, IRQ_VECTOR}, "vector load");
  endtask

  task automatic service(input logic [7:0] en, input logic [7:0] fl);
    logic [63:0] expCtx;
    axiRd(ADDR_CTRL, {24'h0, en | fl}, RESP_OKAY);
    axiWr(ADDR_PFLAG, 8'h00, RESP_OKAY);
    axiWr(ADDR_CTRL, en, RESP_OKAY);
    @(posedge mclk);
    retfieExec <= 1'b1;
    @(posedge mclk);
    retfieExec <= 1'b0;
    @(posedge mclk);
    expCtx = (saved & ~CTX_KEEP_MASK) | ((ctxLive - STEP) & CTX_KEEP_MASK);
    chk({stackPop, ctxRestore}, 2'b11, "return pulses");
    chk(ctxRestored, expCtx, "restored context");
    axiRd(ADDR_CTRL, {24'h0, en | 8'h80}, RESP_OKAY);
    noPush(8);
  endtask

  task automatic tReset();
    int q;
    axiRd(ADDR_CTRL, 32'h0, RESP_OKAY);
    axiRd(ADDR_OPT, 32'h1, RESP_OKAY);
    axiRd(ADDR_PENA, 32'h0, RESP_OKAY);
    axiWr(4'h2, 8'hff, RESP_SLVERR);
    axiRd(4'h2, 32'h0, RESP_SLVERR);
    chk(pcLoadAddr, IRQ_VECTOR, "vector idle");
    q = qPhase;
    repeat (5) begin
      @(posedge mclk);
      q = (q + 1) % 4;
      chk(qPhase, q, "phase count");
    end
    axiWr(ADDR_CTRL, 8'h80, RESP_OKAY);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    axiRd(ADDR_CTRL, 32'h0, RESP_OKAY);
  endtask

  task automatic tGate();
    int n;
    @(posedge mclk);
    coreEvent <= 1'b1;
    periphEvent <= 8'h81;
    @(posedge mclk);
    coreEvent <= 1'b0;
    periphEvent <= 8'h00;
    axiRd(ADDR_CTRL, 32'h04, RESP_OKAY);
    axiRd(ADDR_PFLAG, 32'h81, RESP_OKAY);
    axiWr(ADDR_PENA, 8'h01, RESP_OKAY);
    axiWr(ADDR_CTRL, 8'h84, RESP_OKAY);
    noPush(12);
    axiWr(ADDR_CTRL, 8'hc4, RESP_OKAY);
    waitVec(12, n);
    service(8'h40, 8'h04);
    axiWr(ADDR_CTRL, 8'ha0, RESP_OKAY);
    @(posedge mclk);
    coreEvent <= 1'b1;
    @(posedge mclk);
    coreEvent <= 1'b0;
    waitVec(16, n);
    chk(n + 5 > 8 && n + 5 <= 16, 1'b1, "sync latency");
    service(8'h20, 8'h04);
  endtask

  task automatic tExt();
    int n, p;
    for (p = 0; p < 2; p++) begin
      @(posedge mclk);
      extIrqPin <= p[0];
      axiWr(ADDR_OPT, {7'h0, p[0]}, RESP_OKAY);
      axiWr(ADDR_CTRL, 8'h90, RESP_OKAY);
      @(posedge mclk);
      extIrqPin <= ~p[0];
      noPush(12);
      axiRd(ADDR_CTRL, 32'h90, RESP_OKAY);
      @(posedge mclk);
      extIrqPin <= p[0];
      waitVec(24, n);
      chk(n + 5 > 8 && n + 5 <= 20, 1'b1, "async latency");
      service(8'h10, 8'h02);
    end
  endtask

  task automatic tSleep();
    int n;
    @(posedge mclk);
    cpuAsleep <= 1'b1;
    axiWr(ADDR_CTRL, 8'ha0, RESP_OKAY);
    @(posedge mclk);
    coreEvent <= 1'b1;
    @(posedge mclk);
    coreEvent <= 1'b0;
    noPush(8);
    chk(wakeReq, 1'b1, "wake request");
    @(posedge mclk);
    cpuAsleep <= 1'b0;
    noPush(4);
    waitVec(10, n);
    service(8'h20, 8'h04);
  endtask

  initial begin
    miscompares = 0;
    testsRun = 0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, coreEvent} = 6'h00;
    {extIrqPin, cpuAsleep, retfieExec} = 3'h0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'hf;
    wdata = 32'h0;
    periphEvent = 8'h00;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    tReset();
    tGate();
    tExt();
    tSleep();
    testDone();
  end

  // the whole run needs well under two thousand clocks
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    testDone();
  end
endmodule
